/* File: src/hbpc_pkg.sv */
package hbpc_pkg;
	// register byte addresses (the bridge control offset is printed; the rest are placed alongside it)
	localparam logic [7:0] ADDR_OUTPUT   = 8'h04;
	localparam logic [7:0] ADDR_BRIDGE   = 8'h08;
	localparam logic [7:0] ADDR_SYSTEM_CONTROL_REGISTER   = 8'h0c;
	localparam logic [7:0] ADDR_SYSTEM_STATUS_REGISTER  = 8'h10;
	localparam logic [7:0] ADDR_IFLAG    = 8'h14;
	localparam logic [7:0] ADDR_IMASK    = 8'h18;
	localparam logic [7:0] ADDR_ISTAT    = 8'h1c;
	// bridge control fields
	localparam int         BC_CHOP_BIT   = 7;
	localparam int         BC_GAIN_BIT   = 6;
	localparam int         BC_CLS_LSB    = 0;
	localparam int         BC_CLS_W      = 3;
	localparam logic [7:0] BC_RESET      = 8'h00;
	localparam logic [7:0] BC_WMASK      = 8'hc7;
	// system control fields
	localparam int         SC_POWER_STAGE_ON_BIT   = 0;
	localparam int         SC_HTRST_BIT  = 1;
	localparam logic [1:0] SC_RESET      = 2'h0;
	// system status: bridge over-current flag
	localparam int         SS_OCF_BIT    = 0;
	// interrupt flag register fields
	localparam int         IF_HOT_BIT    = 0;
	localparam int         IF_LOW_BIT    = 1;
	localparam int         IF_HIGH_BIT   = 2;
	// sticky event status fields
	localparam int         EV_OCF        = 0;
	localparam int         EV_HOT        = 1;
	localparam int         EV_LOW        = 2;
	localparam int         EV_HIGH       = 3;
	localparam int         EV_RECIRC     = 4;
	localparam int         EV_W          = 5;
	localparam logic [7:0] OUT_RESET     = 8'h00;
	localparam int         SYNC_W        = 17;
endpackage

/* File: src/hbpc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module hbpc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* File: src/hbpc_top.sv */
// What this block does
// - with chop enabled, low sides 1,2 turn on at chop rise, 3,4 at fall
// - gain select one picks 500 mA range, zero picks 2.5 A range
// - recirculation output high exactly while any bridge senses recirculation
// - over-temperature prewarning sets the hot flag in interrupt flag register
// - hot limit with high-temperature reset enabled issues reset, kills all outputs
// - any high-side over-current switches off all four high sides
// - any low-side over-current switches off all four low sides
// - either over-current sets bridge over-current flag in system status
// - writing one or reset clears over-current flag and re-enables outputs
// - while low or high supply flag set, all outputs stay disabled
// - writing one or reset clears a supply flag and re-enables outputs
// - clearing a supply flag is futile while the supply fault persists
// - bridge control: chop bit 7, gain bit 6, limit bits 2..0, 5..3 zero
// - reset clears every bit of bridge control
// - no transistor turns on unless power stage on bit is set
// - both on-bits set in a bridge: only high side turns on
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module hbpc_top (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog sense inputs (asynchronous)
	input  wire logic        chop_pulse_source,
	input  wire logic [3:0]  recirc_sense,
	input  wire logic [3:0]  hs_overcurrent,
	input  wire logic [3:0]  ls_overcurrent,
	input  wire logic        hot_prewarn,
	input  wire logic        hot_limit,
	input  wire logic        low_supply,
	input  wire logic        high_supply,
	// gate drives for bridge_outputs_one_to_four
	output logic      [3:0]  high_side_gate,
	output logic      [3:0]  low_side_gate,
	// status outputs
	output logic             recirculation_detect,
	output logic             sense_gain_select,
	output logic      [2:0]  current_limit_select,
	output logic             thermal_reset_req,
	output logic             irq
);
	typedef enum logic [1:0] {
		HBPC_CHOP_IDLE = 2'b00,
		HBPC_CHOP_HIGH = 2'b01,
		HBPC_CHOP_LOW  = 2'b10
	} hbpc_chop_t;

	logic [16:0] s_q;
	logic        chop_s;
	logic [3:0]  recirc_s;
	logic [3:0]  hs_oc_s;
	logic [3:0]  ls_oc_s;
	logic        hot_pw_s;
	logic        hot_lim_s;
	logic        low_s;
	logic        high_s;

	hbpc_sync #(.W(hbpc_pkg::SYNC_W)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({chop_pulse_source, recirc_sense, hs_overcurrent, ls_overcurrent,
		           hot_prewarn, hot_limit, low_supply, high_supply}),
		.q       (s_q)
	);

	assign chop_s    = s_q[16];
	assign recirc_s  = s_q[15:12];
	assign hs_oc_s   = s_q[11:8];
	assign ls_oc_s   = s_q[7:4];
	assign hot_pw_s  = s_q[3];
	assign hot_lim_s = s_q[2];
	assign low_s     = s_q[1];
	assign high_s    = s_q[0];

	// apb decode: zero wait states
	logic wr_en;
	logic rd_en;
	logic rd_setup;
	assign pready  = 1'b1;
	// read data is captured in the setup cycle so it stands through the access cycle
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;

	logic [7:0]      out_reg;
	logic [7:0]      bridge_reg;
	logic [1:0]      system_control_register_reg;
	logic            ocf_reg;
	logic            hs_trip_reg;
	logic            ls_trip_reg;
	logic [2:0]      iflag_reg;
	logic [4:0]      mask_reg;
	logic [4:0]      ev_reg;
	logic            recirc_prev_reg;
	logic            chop_prev_reg;
	hbpc_chop_t      chop_reg;
	logic [3:0]      chop_ls_reg;
	logic [31:0]     rdata_next;
	logic            err_next;
	logic            hit;

	always_comb begin
		rdata_next = 32'h0000_0000;
		hit        = 1'b1;
		if (paddr == hbpc_pkg::ADDR_OUTPUT) begin
			rdata_next[7:0] = out_reg;
		end else if (paddr == hbpc_pkg::ADDR_BRIDGE) begin
			rdata_next[7:0] = bridge_reg & hbpc_pkg::BC_WMASK;
		end else if (paddr == hbpc_pkg::ADDR_SYSTEM_CONTROL_REGISTER) begin
			rdata_next[1:0] = system_control_register_reg;
		end else if (paddr == hbpc_pkg::ADDR_SYSTEM_STATUS_REGISTER) begin
			rdata_next[hbpc_pkg::SS_OCF_BIT] = ocf_reg;
		end else if (paddr == hbpc_pkg::ADDR_IFLAG) begin
			rdata_next[2:0] = iflag_reg;
		end else if (paddr == hbpc_pkg::ADDR_IMASK) begin
			rdata_next[4:0] = mask_reg;
		end else if (paddr == hbpc_pkg::ADDR_ISTAT) begin
			rdata_next[4:0] = ev_reg;
		end else begin
			hit = 1'b0;
		end
		err_next = !hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rdata_next;
		end
	end

	assign pslverr = psel && penable && err_next;

	// software control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg    <= hbpc_pkg::OUT_RESET;
			bridge_reg <= hbpc_pkg::BC_RESET;
			system_control_register_reg <= hbpc_pkg::SC_RESET;
			mask_reg   <= 5'h00;
		end else if (wr_en) begin
			if (paddr == hbpc_pkg::ADDR_OUTPUT) begin
				out_reg <= pwdata[7:0];
			end else if (paddr == hbpc_pkg::ADDR_BRIDGE) begin
				bridge_reg <= pwdata[7:0] & hbpc_pkg::BC_WMASK;
			end else if (paddr == hbpc_pkg::ADDR_SYSTEM_CONTROL_REGISTER) begin
				system_control_register_reg <= pwdata[1:0];
			end else if (paddr == hbpc_pkg::ADDR_IMASK) begin
				mask_reg <= pwdata[4:0];
			end
		end
	end

	assign sense_gain_select    = bridge_reg[hbpc_pkg::BC_GAIN_BIT];
	assign current_limit_select = bridge_reg[hbpc_pkg::BC_CLS_LSB +: hbpc_pkg::BC_CLS_W];

	logic ocf_w1c;
	logic low_w1c;
	logic high_w1c;
	logic hot_w1c;
	assign ocf_w1c  = wr_en && paddr == hbpc_pkg::ADDR_SYSTEM_STATUS_REGISTER && pwdata[hbpc_pkg::SS_OCF_BIT];
	assign hot_w1c  = wr_en && paddr == hbpc_pkg::ADDR_IFLAG && pwdata[hbpc_pkg::IF_HOT_BIT];
	assign low_w1c  = wr_en && paddr == hbpc_pkg::ADDR_IFLAG && pwdata[hbpc_pkg::IF_LOW_BIT];
	assign high_w1c = wr_en && paddr == hbpc_pkg::ADDR_IFLAG && pwdata[hbpc_pkg::IF_HIGH_BIT];

	// over-current latch: set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocf_reg     <= 1'b0;
			hs_trip_reg <= 1'b0;
			ls_trip_reg <= 1'b0;
		end else begin
			if (|hs_oc_s) begin
				hs_trip_reg <= 1'b1;
			end else if (ocf_w1c) begin
				hs_trip_reg <= 1'b0;
			end
			if (|ls_oc_s) begin
				ls_trip_reg <= 1'b1;
			end else if (ocf_w1c) begin
				ls_trip_reg <= 1'b0;
			end
			if (|hs_oc_s || |ls_oc_s) begin
				ocf_reg <= 1'b1;
			end else if (ocf_w1c) begin
				ocf_reg <= 1'b0;
			end
		end
	end

	// supply and thermal flags; a live fault re-sets the flag at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iflag_reg <= 3'h0;
		end else begin
			if (hot_pw_s) begin
				iflag_reg[hbpc_pkg::IF_HOT_BIT] <= 1'b1;
			end else if (hot_w1c) begin
				iflag_reg[hbpc_pkg::IF_HOT_BIT] <= 1'b0;
			end
			if (low_s) begin
				iflag_reg[hbpc_pkg::IF_LOW_BIT] <= 1'b1;
			end else if (low_w1c) begin
				iflag_reg[hbpc_pkg::IF_LOW_BIT] <= 1'b0;
			end
			if (high_s) begin
				iflag_reg[hbpc_pkg::IF_HIGH_BIT] <= 1'b1;
			end else if (high_w1c) begin
				iflag_reg[hbpc_pkg::IF_HIGH_BIT] <= 1'b0;
			end
		end
	end

	// thermal reset request: only while the enable is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thermal_reset_req <= 1'b0;
		end else begin
			thermal_reset_req <= hot_lim_s && system_control_register_reg[hbpc_pkg::SC_HTRST_BIT];
		end
	end

	// offset chopping: low sides wait for their chop edge before turning on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chop_prev_reg <= 1'b0;
			chop_reg      <= HBPC_CHOP_IDLE;
			chop_ls_reg   <= 4'h0;
		end else begin
			chop_prev_reg <= chop_s;
			if (!bridge_reg[hbpc_pkg::BC_CHOP_BIT]) begin
				chop_reg    <= HBPC_CHOP_IDLE;
				chop_ls_reg <= 4'hf;
			end else begin
				case (chop_reg)
					HBPC_CHOP_IDLE: begin
						chop_ls_reg <= 4'h0;
						chop_reg    <= chop_s ? HBPC_CHOP_HIGH : HBPC_CHOP_LOW;
					end
					HBPC_CHOP_HIGH: begin
						if (!chop_s) begin
							chop_ls_reg <= chop_ls_reg | 4'hc;
							chop_reg    <= HBPC_CHOP_LOW;
						end
					end
					HBPC_CHOP_LOW: begin
						if (chop_s) begin
							chop_ls_reg <= chop_ls_reg | 4'h3;
							chop_reg    <= HBPC_CHOP_HIGH;
						end
					end
					default: chop_reg <= HBPC_CHOP_IDLE;
				endcase
			end
		end
	end

	// gate drive composition, registered
	logic [3:0] hs_req;
	logic [3:0] ls_req;
	logic       kill_all;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_req
			assign hs_req[gi] = out_reg[2*gi+1];
			assign ls_req[gi] = out_reg[2*gi] && !out_reg[2*gi+1];
		end
	endgenerate
	// supply flags as well as raw levels gate outputs so a stale flag also blocks
	assign kill_all = !system_control_register_reg[hbpc_pkg::SC_POWER_STAGE_ON_BIT]
		|| iflag_reg[hbpc_pkg::IF_LOW_BIT] || iflag_reg[hbpc_pkg::IF_HIGH_BIT]
		|| low_s || high_s
		|| (hot_lim_s && system_control_register_reg[hbpc_pkg::SC_HTRST_BIT]);
	// raw levels cut the gates in the same cycle the flag is set, saving one cycle of exposure

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_side_gate <= 4'h0;
			low_side_gate  <= 4'h0;
		end else begin
			high_side_gate <= (kill_all || hs_trip_reg || (|hs_oc_s)) ? 4'h0 : hs_req;
			low_side_gate  <= (kill_all || ls_trip_reg || (|ls_oc_s)) ? 4'h0 : (ls_req & chop_ls_reg);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recirculation_detect <= 1'b0;
			recirc_prev_reg      <= 1'b0;
		end else begin
			recirculation_detect <= |recirc_s;
			recirc_prev_reg      <= |recirc_s;
		end
	end

	// sticky events, cleared by reading the event status; set wins over clear
	logic [4:0] ev_set;
	logic       ev_rd;
	assign ev_set = {(|recirc_s) && !recirc_prev_reg, high_s, low_s, hot_pw_s, (|hs_oc_s) || (|ls_oc_s)};
	assign ev_rd  = rd_en && paddr == hbpc_pkg::ADDR_ISTAT;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_reg <= 5'h00;
			irq    <= 1'b0;
		end else begin
			// only bits already returned are cleared, so an event during the read is kept
			ev_reg <= (ev_rd ? (ev_reg & ~prdata[4:0]) : ev_reg) | ev_set;
			irq    <= |(((ev_rd ? (ev_reg & ~prdata[4:0]) : ev_reg) | ev_set) & mask_reg);
		end
	end
endmodule
`default_nettype wire

/* File: tb/hbpc_load.sv */
`timescale 1ns/1ns
`default_nettype none
module hbpc_load (
	// gate drives
	input wire logic [3:0] high_side_gate,
	input wire logic [3:0] low_side_gate,
	// fault commands
	input wire logic [3:0] short_hs,
	input wire logic [3:0] short_ls,
	input wire logic [3:0] stall,
	// sense back
	output logic     [3:0] hs_overcurrent,
	output logic     [3:0] ls_overcurrent,
	output logic     [3:0] recirc_sense
);
	// a short draws current only while its transistor conducts, so the over-current sense drops once the gate is off
	assign hs_overcurrent = short_hs & high_side_gate;
	assign ls_overcurrent = short_ls & low_side_gate;
	// freewheeling only once both transistors of a stalled bridge are off
	assign recirc_sense = stall & ~(high_side_gate | low_side_gate);
endmodule
`default_nettype wire

/* File: tb/hbpc_top_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module hbpc_top_monitor (
	// bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// sense and drive
	input wire logic [3:0]  recirc_sense,
	input wire logic [3:0]  hs_overcurrent,
	input wire logic [3:0]  ls_overcurrent,
	input wire logic        low_supply,
	input wire logic        high_supply,
	input wire logic [3:0]  high_side_gate,
	input wire logic [3:0]  low_side_gate,
	input wire logic        recirculation_detect,
	input wire logic        sense_gain_select,
	input wire logic [2:0]  current_limit_select
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr_bc;
	logic [7:0] gates;
	assign wr_bc = psel && penable && pwrite && paddr == hbpc_pkg::ADDR_BRIDGE;
	assign gates = {high_side_gate, low_side_gate};
	// pins cross two sync flops and an output flop, so every pin reaction is ##3
	AST_ONE_SIDE: assert property ((high_side_gate & low_side_gate) == 4'h0) else $error("both on");
	AST_HS_TRIP: assert property (|hs_overcurrent |-> ##3 high_side_gate == 4'h0) else $error("hs on");
	AST_LS_TRIP: assert property (|ls_overcurrent |-> ##3 low_side_gate == 4'h0) else $error("ls on");
	AST_SUPPLY: assert property ((low_supply || high_supply) |-> ##3 gates == 8'h00) else $error("supply");
	AST_REC_ON: assert property (|recirc_sense |-> ##3 recirculation_detect) else $error("rec low");
	AST_REC_OFF: assert property (recirc_sense == 4'h0 |-> ##3 !recirculation_detect) else $error("rec high");
	AST_GAIN: assert property (wr_bc |=> sense_gain_select == $past(pwdata[6])) else $error("gain");
	AST_LIMIT: assert property (wr_bc |=> current_limit_select == $past(pwdata[2:0])) else $error("limit");
	AST_RST_CLR: assert property ($rose(presetn) |-> !sense_gain_select && current_limit_select == 3'h0) else $error("rst");
	cover property (wr_bc);
	cover property (|hs_overcurrent ##3 high_side_gate == 4'h0);
	cover property (low_supply ##3 gates == 8'h00);
endmodule
bind hbpc_top hbpc_top_monitor u_mon (.*);
`default_nettype wire

/* File: tb/test_half_bridge_protect_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_half_bridge_protect_ctrl;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se, chop_pulse_source;
	logic        hot_prewarn, hot_limit, low_supply, high_supply, recirculation_detect;
	logic        sense_gain_select, thermal_reset_req, irq;
	logic [2:0]  current_limit_select;
	logic [7:0]  paddr, o;
	logic [31:0] pwdata, prdata, rdat, d;
	logic [3:0]  recirc_sense, hs_overcurrent, ls_overcurrent, high_side_gate, low_side_gate;
	logic [3:0]  short_hs, short_ls, stall;
	int          err_total, n_compared, cycles;
	integer      seed;

	hbpc_top uut (.*);
	hbpc_load u_load (.*);

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// read data and error are taken at the edge where pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		se = pslverr;
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [7:0] exp_gates(input logic [7:0] v, input logic on);
		logic [7:0] g;
		g = 8'h00;
		for (int n = 0; n < 4; n++) begin
			g[4+n] = on & v[2*n+1];
			g[n] = on & v[2*n] & ~v[2*n+1];
		end
		return g;
	endfunction

	task automatic gchk(input logic [7:0] v, input logic on);
		wt(4);
		chk({high_side_gate, low_side_gate}, exp_gates(v, on));
	endtask

	initial begin
		seed = 32'h6832ee16;
		{presetn, psel, penable, pwrite, paddr, pwdata, chop_pulse_source} = '0;
		{hot_prewarn, hot_limit, low_supply, high_supply, short_hs, short_ls, stall} = '0;
		err_total = 0;
		n_compared = 0;
		cycles = 0;
		wt(5);
		presetn <= 1'b1;
		apb(1'b0, hbpc_pkg::ADDR_BRIDGE, 32'h0);
		chk(rdat, 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 32'hffffffff : $random(seed);
			apb(1'b1, hbpc_pkg::ADDR_BRIDGE, d);
			apb(1'b0, hbpc_pkg::ADDR_BRIDGE, 32'h0);
			chk(rdat, d & 32'hc7);
			chk({sense_gain_select, current_limit_select}, {d[6], d[2:0]});
		end
		apb(1'b0, 8'h00, 32'h0);
		chk({rdat[30:0], se}, 32'h1);
		apb(1'b1, hbpc_pkg::ADDR_BRIDGE, 32'h0);
		apb(1'b1, hbpc_pkg::ADDR_OUTPUT, 32'hff);
		gchk(8'hff, 1'b0);
		apb(1'b1, hbpc_pkg::ADDR_SYSTEM_CONTROL_REGISTER, 32'h1);
		for (int i = 0; i < 6; i++) begin
			o = (i == 0) ? 8'hff : 8'($random(seed));
			apb(1'b1, hbpc_pkg::ADDR_OUTPUT, {24'h0, o});
			gchk(o, 1'b1);
		end
		$display("test registers and gates ends");
		for (int s = 0; s < 2; s++) begin
			o = s ? 8'h55 : 8'haa;
			apb(1'b1, hbpc_pkg::ADDR_IMASK, s ? 32'h0 : 32'h1f);
			apb(1'b1, hbpc_pkg::ADDR_OUTPUT, {24'h0, o});
			apb(1'b0, hbpc_pkg::ADDR_ISTAT, 32'h0);
			short_hs <= s ? 4'h0 : 4'h2;
			short_ls <= s ? 4'h4 : 4'h0;
			gchk(o, 1'b0);
			chk(irq, s ? 32'h0 : 32'h1);
			apb(1'b0, hbpc_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h0);
			chk(rdat[0], 1'b1);
			apb(1'b0, hbpc_pkg::ADDR_ISTAT, 32'h0);
			chk(rdat[0], 1'b1);
			wt(1);
			chk(irq, 1'b0);
			short_hs <= 4'h0;
			short_ls <= 4'h0;
			apb(1'b1, hbpc_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h1);
			gchk(o, 1'b1);
		end
		o = 8'h66;
		apb(1'b1, hbpc_pkg::ADDR_OUTPUT, {24'h0, o});
		for (int s = 0; s < 2; s++) begin
			high_supply <= s[0];
			low_supply <= !s[0];
			gchk(o, 1'b0);
			apb(1'b1, hbpc_pkg::ADDR_IFLAG, 32'h6);
			apb(1'b0, hbpc_pkg::ADDR_IFLAG, 32'h0);
			chk(rdat[2:1], s ? 2'h2 : 2'h1);
			gchk(o, 1'b0);
			low_supply <= 1'b0;
			high_supply <= 1'b0;
			wt(4);
			apb(1'b1, hbpc_pkg::ADDR_IFLAG, 32'h6);
			gchk(o, 1'b1);
		end
		hot_prewarn <= 1'b1;
		wt(4);
		apb(1'b0, hbpc_pkg::ADDR_IFLAG, 32'h0);
		chk(rdat[0], 1'b1);
		hot_prewarn <= 1'b0;
		apb(1'b1, hbpc_pkg::ADDR_SYSTEM_CONTROL_REGISTER, 32'h3);
		apb(1'b1, hbpc_pkg::ADDR_BRIDGE, 32'h47);
		hot_limit <= 1'b1;
		gchk(o, 1'b0);
		chk(thermal_reset_req, 1'b1);
		hot_limit <= 1'b0;
		presetn <= 1'b0;
		wt(2);
		presetn <= 1'b1;
		apb(1'b0, hbpc_pkg::ADDR_BRIDGE, 32'h0);
		chk(rdat, 32'h0);
		$display("test protection ends");
		apb(1'b1, hbpc_pkg::ADDR_SYSTEM_CONTROL_REGISTER, 32'h1);
		apb(1'b1, hbpc_pkg::ADDR_OUTPUT, 32'hff);
		stall <= 4'h8;
		wt(4);
		chk(recirculation_detect, 1'b0);
		apb(1'b1, hbpc_pkg::ADDR_OUTPUT, 32'h0);
		wt(5);
		chk(recirculation_detect, 1'b1);
		stall <= 4'h0;
		wt(4);
		chk(recirculation_detect, 1'b0);
		apb(1'b1, hbpc_pkg::ADDR_OUTPUT, 32'h55);
		apb(1'b1, hbpc_pkg::ADDR_BRIDGE, 32'h80);
		chop_pulse_source <= 1'b1;
		wt(5);
		chk(low_side_gate, 4'h3);
		chop_pulse_source <= 1'b0;
		wt(5);
		chk(low_side_gate, 4'hf);
		$display("test recirculation and chop ends");
		print_verdict();
	end
endmodule
`default_nettype wire
